// file: pkg/tps_map.vh
// Purpose: constants for the tunnel packet signing block
// Assumes: IPv4 packets, big-endian 32-bit words, first byte in [31:24]
// Notes:   word offsets of RTP fields are relative to the IP header length
`ifndef TPS_MAP_VH
`define TPS_MAP_VH

// --------------------------------------------------------------------
// header extension layout
// --------------------------------------------------------------------
`define TPS_EXT_RSVD      13'h1fff
`define TPS_EXT_LEN       16'h0004
`define TPS_KEY_NONE      3'h0
`define TPS_KEY_FIRST     3'h1
`define TPS_KEY_LAST      3'h4
`define TPS_TAG_WORDS     4'h4

// --------------------------------------------------------------------
// word positions inside the packet
// --------------------------------------------------------------------
`define TPS_IP_SRC_WORD   4'h3
`define TPS_UDP_OFS       4'h0
`define TPS_RTP_OFS       4'h2
`define TPS_TS_OFS        4'h3
`define TPS_EXT_OFS       4'h5
`define TPS_TAG_OFS       4'h6
`define TPS_MIN_OFS       4'ha
`define TPS_RTP_X_BIT     28

// --------------------------------------------------------------------
// initialization value and field arithmetic
// --------------------------------------------------------------------
`define TPS_IV_TIME_W     10
`define TPS_IV_SRC_W      22
`define TPS_J0_CTR        32'h00000001
`define TPS_GF_POLY       128'he1000000000000000000000000000000
`define TPS_GF_STEPS      8'h7f

`endif

// file: verilog/tps_gf_mult.v
// Purpose: bit-serial multiply in the 128-bit Galois field of GCM
// Assumes: start_i is a one-cycle pulse taken only while idle
// Notes:   result valid with done_o, 128 cycles after start
`timescale 1ns/10ps
`default_nettype none
`include "tps_map.vh"

module tps_gf_mult (
  // clock and reset
  input  wire         clk_sys_i,
  input  wire         rst_i,
  // operands
  input  wire         start_i,
  input  wire [127:0] a_i,
  input  wire [127:0] b_i,
  // result
  output wire         busy_o,
  output wire         done_o,
  output wire [127:0] p_o
);

  reg [127:0] z_ff;
  reg [127:0] v_ff;
  reg [127:0] x_ff;
  reg [7:0]   cnt_ff;
  reg         busy_ff;
  reg         done_ff;

  // ------------------------------------------------------------------
  // shift-and-add, msb of the operand first
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      z_ff    <= 128'h0;
      v_ff    <= 128'h0;
      x_ff    <= 128'h0;
      cnt_ff  <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start_i && !busy_ff) begin
        z_ff    <= 128'h0;
        v_ff    <= b_i;
        x_ff    <= a_i;
        cnt_ff  <= 8'h00;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (x_ff[127])
          z_ff <= z_ff ^ v_ff;
        if (v_ff[0])
          v_ff <= (v_ff >> 1) ^ `TPS_GF_POLY;
        else
          v_ff <= v_ff >> 1;
        x_ff   <= {x_ff[126:0], 1'b0};
        cnt_ff <= cnt_ff + 8'h01;
        if (cnt_ff == `TPS_GF_STEPS) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign p_o    = z_ff;

endmodule
`default_nettype wire

// file: verilog/tps_signer.v
// Purpose: signs tunneled RTP/UDP/IP packets with a Auth_tag_field
// Assumes: packet arrives with the 20-byte extension space already
//          reserved after the SSRC; lengths and checksums set upstream
// Notes:   the AES-256 cipher and key token sit outside, on cipher_*
//
// Operation
// - GCM used for authentication only; packet is AAD, nothing encrypted
// - cipher uses 256-bit keys on 128-bit blocks
// - every tag is exactly 128 bits
// - every selected packet of ihl+10 to DEPTH words gets its tag in its own header extension
// - 96-bit IV: time 10, source 22, port 16, seq 16, timestamp 32
// - IV time part is top 10 bits of frame emission time
// - IV source part is low 22 bits of gateway IP source
// - IV carries UDP destination port then RTP sequence number
// - IV ends with the full 32-bit RTP timestamp as carried
// - IV never repeats per key and comes from emission time and header fields
// - four keys; the key used is signalled in the extension
// - extension follows SSRC and RTP extension flag is set
// - extension: 13 ones, 3-bit key index, 16-bit length, tag
// - key 0 unsigned, 1 to 4 pick a key, 5 to 7 never emitted
// - length counts words after it; signing alone writes 0x0004
// - tag comes from selected key, IV and hash over the packet
// - tag field cleared to zero before hashing
// - hash whole packet from IP header to payload end, then encrypt
// - tag written into the field before the packet is sent
// - security data stream packets are never signed here
`timescale 1ns/10ps
`default_nettype none
`include "tps_map.vh"

module tps_signer #(
  parameter DEPTH = 512,
  parameter AW    = 9
) (
  // clock and reset
  input  wire         clk_sys_i,
  input  wire         rst_i,
  // packet in
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [31:0]  in_data_i,
  input  wire         in_last_i,
  input  wire [1:0]   in_last_bytes_i,
  input  wire [2:0]   in_key_idx_i,
  input  wire         in_security_stream_i,
  input  wire [31:0]  in_emission_time_i,
  // packet out
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [31:0]  out_data_o,
  output wire         out_last_o,
  output wire [1:0]   out_last_bytes_o,
  output wire         out_signed_o,
  // block cipher
  output wire         cipher_req_o,
  output wire [2:0]   cipher_key_idx_o,
  output wire [127:0] cipher_blk_o,
  input  wire         cipher_ack_i,
  input  wire [127:0] cipher_res_i
);

  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_RECV = 9'h002;
  localparam [8:0] ST_HKEY = 9'h004;
  localparam [8:0] ST_HASH = 9'h008;
  localparam [8:0] ST_MUL  = 9'h010;
  localparam [8:0] ST_WAIT = 9'h020;
  localparam [8:0] ST_TAGE = 9'h040;
  localparam [8:0] ST_TAGW = 9'h080;
  localparam [8:0] ST_SEND = 9'h100;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function [31:0] keep_bytes;
    input [31:0] w;
    input [1:0]  nb;
    begin
      case (nb)
        2'h1:    keep_bytes = {w[31:24], 24'h0};
        2'h2:    keep_bytes = {w[31:16], 16'h0};
        2'h3:    keep_bytes = {w[31:8], 8'h0};
        default: keep_bytes = w;
      endcase
    end
  endfunction

  function [AW:0] ofs;
    input [3:0] ihl;
    input [3:0] add;
    begin
      ofs = {{(AW-3){1'b0}}, ihl} + {{(AW-3){1'b0}}, add};
    end
  endfunction

  reg [31:0]  mem [0:DEPTH-1];
  reg [8:0]   state_ff;
  reg [AW:0]  cnt_ff;
  reg [AW:0]  nwords_ff;
  reg [AW:0]  rd_ff;
  reg [1:0]   sub_ff;
  reg [1:0]   tail_ff;
  reg [3:0]   ihl_ff;
  reg [2:0]   key_ff;
  reg         sign_ff;
  reg         len_ff;
  reg [95:0]  iv_ff;
  reg [127:0] h_ff;
  reg [127:0] blk_ff;
  reg [127:0] acc_ff;
  reg [127:0] cblk_ff;
  reg         mul_go_ff;
  reg [31:0]  odata_ff;
  reg         ovalid_ff;
  reg         olast_ff;
  reg [31:0]  wr_word;
  reg [31:0]  rd_word;
  wire        mul_done;
  wire [127:0] mul_p;

  wire in_take  = in_valid_i && in_ready_o;
  wire [AW:0] wa = (state_ff == ST_IDLE) ? {(AW+1){1'b0}} : cnt_ff;
  wire wr_ok    = (wa < DEPTH);
  wire [AW:0] rtp_w = ofs(ihl_ff, `TPS_RTP_OFS);
  wire [AW:0] ext_w = ofs(ihl_ff, `TPS_EXT_OFS);
  wire [AW:0] tag_w = ofs(ihl_ff, `TPS_TAG_OFS);
  wire [AW:0] end_w = ofs(ihl_ff, `TPS_MIN_OFS);
  wire [63:0] len_bits = {{(63-AW-5){1'b0}}, nwords_ff, 5'h0} -
                         {59'h0, tail_ff, 3'h0};
  wire [31:0] mem_word = mem[rd_ff[AW-1:0]];
  wire [31:0] hash_word = (rd_ff < nwords_ff) ? rd_word : 32'h0;
  wire out_free = !ovalid_ff || out_ready_i;

  assign in_ready_o = (state_ff == ST_IDLE) || (state_ff == ST_RECV);

  // ------------------------------------------------------------------
  // X flag and extension word go in on read, the tag is written into the buffer; an unsigned packet leaves unchanged
  // ------------------------------------------------------------------
  always @* begin
    wr_word = in_data_i;
    if (in_last_i)
      wr_word = keep_bytes(in_data_i, in_last_bytes_i);
  end

  always @* begin
    rd_word = mem_word;
    if (sign_ff) begin
      if (rd_ff == rtp_w)
        rd_word[`TPS_RTP_X_BIT] = 1'b1;
      if (rd_ff == ext_w)
        rd_word = {`TPS_EXT_RSVD, key_ff, `TPS_EXT_LEN};
      if (state_ff == ST_HASH && rd_ff >= tag_w && rd_ff < end_w)
        rd_word = 32'h0;
    end
  end

  always @(posedge clk_sys_i) begin
    if (in_take && wr_ok)
      mem[wa[AW-1:0]] <= wr_word;
    else if (state_ff == ST_TAGW)
      mem[rd_ff[AW-1:0]] <= blk_ff[127:96];
  end

  // ------------------------------------------------------------------
  // control
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= {(AW+1){1'b0}};
      nwords_ff <= {(AW+1){1'b0}};
      rd_ff     <= {(AW+1){1'b0}};
      sub_ff    <= 2'h0;
      tail_ff   <= 2'h0;
      ihl_ff    <= 4'h0;
      key_ff    <= `TPS_KEY_NONE;
      sign_ff   <= 1'b0;
      len_ff    <= 1'b0;
      iv_ff     <= 96'h0;
      h_ff      <= 128'h0;
      blk_ff    <= 128'h0;
      acc_ff    <= 128'h0;
      cblk_ff   <= 128'h0;
      mul_go_ff <= 1'b0;
      odata_ff  <= 32'h0;
      ovalid_ff <= 1'b0;
      olast_ff  <= 1'b0;
    end else begin
      mul_go_ff <= 1'b0;
      if (in_take) begin
        if (cnt_ff < DEPTH || state_ff == ST_IDLE)
          cnt_ff <= wa + {{AW{1'b0}}, 1'b1};
        if (wa == {{(AW-3){1'b0}}, `TPS_IP_SRC_WORD})
          iv_ff[85:64] <= in_data_i[`TPS_IV_SRC_W-1:0];
        if (wa == ofs(ihl_ff, `TPS_UDP_OFS))
          iv_ff[63:48] <= in_data_i[15:0];
        if (wa == rtp_w)
          iv_ff[47:32] <= in_data_i[15:0];
        if (wa == ofs(ihl_ff, `TPS_TS_OFS))
          iv_ff[31:0] <= in_data_i;
        if (in_last_i) begin
          nwords_ff <= wr_ok ? wa + {{AW{1'b0}}, 1'b1} : wa;
          tail_ff   <= 2'h0 - in_last_bytes_i;
          rd_ff     <= {(AW+1){1'b0}};
          sub_ff    <= 2'h0;
          len_ff    <= 1'b0;
          acc_ff    <= 128'h0;
        end
      end
      case (state_ff)
        ST_IDLE: begin
          if (in_take) begin
            ihl_ff  <= in_data_i[27:24];
            key_ff  <= in_key_idx_i;
            // keys 5..7 and the security stream pass unsigned
            sign_ff <= !in_security_stream_i &&
                       in_key_idx_i >= `TPS_KEY_FIRST &&
                       in_key_idx_i <= `TPS_KEY_LAST;
            iv_ff[95:86] <= in_emission_time_i[31:22];
            if (in_last_i) begin
              sign_ff  <= 1'b0;
              state_ff <= ST_SEND;
            end else begin
              state_ff <= ST_RECV;
            end
          end
        end
        ST_RECV: begin
          if (in_take && in_last_i) begin
            if (sign_ff && (wa + {{AW{1'b0}}, 1'b1}) >= end_w && wr_ok) begin
              cblk_ff  <= 128'h0;
              state_ff <= ST_HKEY;
            end else begin
              sign_ff  <= 1'b0;
              state_ff <= ST_SEND;
            end
          end
        end
        ST_HKEY: begin
          if (cipher_ack_i) begin
            h_ff     <= cipher_res_i;
            state_ff <= ST_HASH;
          end
        end
        ST_HASH: begin
          blk_ff <= {blk_ff[95:0], hash_word};
          rd_ff  <= rd_ff + {{AW{1'b0}}, 1'b1};
          sub_ff <= sub_ff + 2'h1;
          if (sub_ff == 2'h3)
            state_ff <= ST_MUL;
        end
        ST_MUL: begin
          mul_go_ff <= 1'b1;
          state_ff  <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mul_done) begin
            acc_ff <= mul_p;
            if (len_ff) begin
              cblk_ff  <= {iv_ff, `TPS_J0_CTR};
              state_ff <= ST_TAGE;
            end else if (rd_ff >= nwords_ff) begin
              // closing block: bit length of the AAD, no ciphertext
              blk_ff   <= {len_bits, 64'h0};
              len_ff   <= 1'b1;
              state_ff <= ST_MUL;
            end else begin
              state_ff <= ST_HASH;
            end
          end
        end
        ST_TAGE: begin
          if (cipher_ack_i) begin
            blk_ff   <= cipher_res_i ^ acc_ff;
            rd_ff    <= tag_w;
            sub_ff   <= 2'h0;
            state_ff <= ST_TAGW;
          end
        end
        ST_TAGW: begin
          blk_ff <= {blk_ff[95:0], 32'h0};
          rd_ff  <= rd_ff + {{AW{1'b0}}, 1'b1};
          sub_ff <= sub_ff + 2'h1;
          if (sub_ff == 2'h3) begin
            rd_ff    <= {(AW+1){1'b0}};
            state_ff <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (out_free) begin
            if (rd_ff < nwords_ff) begin
              odata_ff  <= rd_word;
              ovalid_ff <= 1'b1;
              olast_ff  <= (rd_ff + {{AW{1'b0}}, 1'b1} == nwords_ff);
              rd_ff     <= rd_ff + {{AW{1'b0}}, 1'b1};
            end else begin
              ovalid_ff <= 1'b0;
              olast_ff  <= 1'b0;
              state_ff  <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      if (state_ff != ST_SEND && out_ready_i)
        ovalid_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // field multiplier for the hash
  // ------------------------------------------------------------------
  tps_gf_mult u_gf (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (mul_go_ff),
    .a_i       (acc_ff ^ blk_ff),
    .b_i       (h_ff),
    .busy_o    (),
    .done_o    (mul_done),
    .p_o       (mul_p)
  );

  assign cipher_req_o     = (state_ff == ST_HKEY) || (state_ff == ST_TAGE);
  assign cipher_key_idx_o = key_ff;
  assign cipher_blk_o     = cblk_ff;
  assign out_valid_o      = ovalid_ff;
  assign out_data_o       = odata_ff;
  assign out_last_o       = olast_ff;
  assign out_last_bytes_o = olast_ff ? (2'h0 - tail_ff) : 2'h0;
  assign out_signed_o     = sign_ff && ovalid_ff;

endmodule
`default_nettype wire

// file: tb/tps_cipher_model.sv
// Purpose: stand-in block cipher on the signer's cipher port
// Assumes: a held request is answered after delay_i idle cycles
// Notes:   toy keyed permutation, not a real cipher
`timescale 1ns/10ps
`default_nettype none
module tps_cipher_model (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  // cipher port
  input  wire logic         req_i,
  input  wire logic [2:0]   key_i,
  input  wire logic [127:0] blk_i,
  input  wire logic [7:0]   delay_i,
  output logic              ack_o,
  output logic      [127:0] res_o
);
  reg [7:0] cnt_ff;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 8'h00;
      ack_o <= 1'b0;
      res_o <= 128'h0;
    end else begin
      ack_o <= 1'b0;
      // stale result keeps changing so it never looks valid
      res_o <= ~res_o;
      if (req_i && !ack_o) begin
        if (cnt_ff == delay_i) begin
          ack_o <= 1'b1;
          res_o <= {blk_i[0], blk_i[127:1]} ^ {16{5'h15, key_i}};
          cnt_ff <= 8'h00;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tps_signer_props.sv
// Purpose: port-level properties of the packet signer
// Assumes: one packet in flight, ihl taken from the first word
// Notes:   helper logic tracks key, time and output word index
`timescale 1ns/10ps
`default_nettype none
module tps_signer_props #(
  parameter DEPTH = 512,
  parameter AW    = 9
) (
  input wire logic         clk_sys_i,
  input wire logic         rst_i,
  input wire logic         in_valid_i,
  input wire logic         in_ready_o,
  input wire logic [31:0]  in_data_i,
  input wire logic         in_last_i,
  input wire logic [2:0]   in_key_idx_i,
  input wire logic         in_security_stream_i,
  input wire logic [31:0]  in_emission_time_i,
  input wire logic         out_valid_o,
  input wire logic         out_ready_i,
  input wire logic [31:0]  out_data_o,
  input wire logic         out_last_o,
  input wire logic         out_signed_o,
  input wire logic         cipher_req_o,
  input wire logic [2:0]   cipher_key_idx_o,
  input wire logic [127:0] cipher_blk_o,
  input wire logic         cipher_ack_i
);
  // ------------------------------------------------------------
  // packet tracking
  // ------------------------------------------------------------
  wire take = in_valid_i && in_ready_o;
  wire key_ok = (in_key_idx_i >= 3'h1) && (in_key_idx_i <= 3'h4);
  reg first_ff;
  reg bad_ff;
  reg [3:0] ihl_ff;
  reg [2:0] key_ff;
  reg [9:0] time_ff;
  reg [15:0] ocnt_ff;
  wire [15:0] ext_at = {12'h000, ihl_ff} + 16'h0005;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      first_ff <= 1'b1;
      bad_ff <= 1'b0;
      ihl_ff <= 4'h0;
      key_ff <= 3'h0;
      time_ff <= 10'h000;
      ocnt_ff <= 16'h0000;
    end else begin
      if (take)
        first_ff <= in_last_i;
      if (take && first_ff) begin
        bad_ff <= !key_ok || in_security_stream_i;
        ihl_ff <= in_data_i[27:24];
        key_ff <= in_key_idx_i;
        time_ff <= in_emission_time_i[31:22];
      end
      if (out_valid_o && out_ready_i)
        ocnt_ff <= out_last_o ? 16'h0000 : ocnt_ff + 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence req_wait;
    cipher_req_o && !cipher_ack_i;
  endsequence
  sequence h_done;
    cipher_req_o && cipher_ack_i && (cipher_blk_o == 128'h0);
  endsequence
  key_sel_a: assert property (cipher_req_o |-> cipher_key_idx_o == key_ff
    && key_ff >= 3'h1 && key_ff <= 3'h4) else $error("bad cipher key index");
  req_hold_a: assert property (req_wait |=> cipher_req_o
    && $stable(cipher_blk_o) && $stable(cipher_key_idx_o)) else $error("req moved");
  unsigned_a: assert property (bad_ff |-> !cipher_req_o && !out_signed_o)
    else $error("unsigned packet processed as signed");
  busy_out_a: assert property (cipher_req_o |-> !out_valid_o)
    else $error("output before tag ready");
  iv_blk_a: assert property (cipher_req_o && cipher_blk_o != 128'h0 |->
    cipher_blk_o[31:0] == 32'h1 && cipher_blk_o[127:118] == time_ff)
    else $error("counter block malformed");
  h_to_j0_a: assert property (h_done |=> ##[0:999]
    (cipher_req_o && cipher_blk_o[31:0] == 32'h1)) else $error("no J0 request");
  ext_word_a: assert property (out_valid_o && out_signed_o && ocnt_ff == ext_at
    |-> out_data_o == {13'h1fff, key_ff, 16'h0004}) else $error("bad ext word");
  x_flag_a: assert property (out_valid_o && out_signed_o &&
    ocnt_ff == ext_at - 16'h0003 |-> out_data_o[28]) else $error("X bit clear");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o
    && $stable(out_data_o)) else $error("output word dropped");
endmodule
bind tps_signer tps_signer_props #(.DEPTH(DEPTH), .AW(AW)) tps_signer_props_inst (
  .clk_sys_i, .rst_i, .in_valid_i, .in_ready_o, .in_data_i, .in_last_i,
  .in_key_idx_i, .in_security_stream_i, .in_emission_time_i, .out_valid_o,
  .out_ready_i, .out_data_o, .out_last_o, .out_signed_o, .cipher_req_o,
  .cipher_key_idx_o, .cipher_blk_o, .cipher_ack_i);
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the packet signer
// Assumes: IPv4 header of 5 words, RTP at word 7, extension at word 10
// Notes:   expected tag rebuilt with a local GHASH
`timescale 1ns/10ps
`default_nettype none
module testbench;
  reg clk_sys_i = 1'b0;
  reg rst_i = 1'b1;
  reg in_valid_i = 1'b0;
  reg [31:0] in_data_i = 32'h0;
  reg in_last_i = 1'b0;
  reg [1:0] in_last_bytes_i = 2'h0;
  reg [2:0] in_key_idx_i = 3'h0;
  reg in_security_stream_i = 1'b0;
  reg [31:0] in_emission_time_i = 32'h0;
  reg out_ready_i = 1'b1;
  reg [7:0] delay = 8'h00;
  wire in_ready_o, out_valid_o, out_last_o, out_signed_o;
  wire cipher_req_o, cipher_ack_i;
  wire [31:0] out_data_o;
  wire [1:0] out_last_bytes_o;
  wire [2:0] cipher_key_idx_o;
  wire [127:0] cipher_blk_o, cipher_res_i;
  integer err_total = 0;
  integer comparisons = 0;
  integer nb = 0;
  reg [31:0] pkt [0:31];
  reg [31:0] expw [0:31];
  reg [127:0] blks [0:3];
  reg [2:0] kseen [0:3];
  reg [95:0] iv;
  always #25 clk_sys_i = ~clk_sys_i;
  tps_signer #(.DEPTH(64), .AW(6)) tps_signer_inst (.clk_sys_i, .rst_i,
    .in_valid_i, .in_ready_o, .in_data_i, .in_last_i, .in_last_bytes_i,
    .in_key_idx_i, .in_security_stream_i, .in_emission_time_i, .out_valid_o,
    .out_ready_i, .out_data_o, .out_last_o, .out_last_bytes_o, .out_signed_o,
    .cipher_req_o, .cipher_key_idx_o, .cipher_blk_o, .cipher_ack_i,
    .cipher_res_i);
  tps_cipher_model tps_cipher_model_inst (.clk_sys_i, .rst_i,
    .req_i(cipher_req_o), .key_i(cipher_key_idx_o), .blk_i(cipher_blk_o),
    .delay_i(delay), .ack_o(cipher_ack_i), .res_o(cipher_res_i));
  always @(posedge clk_sys_i) begin
    if (cipher_req_o && cipher_ack_i && nb < 4) begin
      blks[nb] = cipher_blk_o;
      kseen[nb] = cipher_key_idx_o;
      nb = nb + 1;
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input string what, input [127:0] seen, input [127:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  function [127:0] enc(input [2:0] k, input [127:0] b);
    enc = {b[0], b[127:1]} ^ {16{5'h15, k}};
  endfunction
  function [127:0] gmul(input [127:0] x, input [127:0] y);
    reg [127:0] z, v;
    integer i;
    begin
      z = 128'h0;
      v = y;
      for (i = 127; i >= 0; i = i - 1) begin
        if (x[i])
          z = z ^ v;
        v = v[0] ? (v >> 1) ^ {8'he1, 120'h0} : v >> 1;
      end
      gmul = z;
    end
  endfunction
  task build(input integer n, input [1:0] lb, input [2:0] key, input sgn,
             input [31:0] tm);
    integer i;
    reg [127:0] y, h;
    begin
      for (i = 0; i < 32; i = i + 1)
        pkt[i] = (i < n && (i < 10 || i > 14)) ? 32'h9e3779b9 * (i + 7) : 0;
      pkt[0] = {16'h4500, 16'(n * 4)};
      pkt[3] = 32'h0a1b2c3d;
      pkt[5] = {16'h1388, 16'd30000 + 16'(key)};
      pkt[7] = {16'h804e, 16'h1000 + 16'(n)};
      pkt[8] = 32'h7f000000 + n;
      if (lb != 2'h0)
        pkt[n - 1] = pkt[n - 1] & ~(32'hffffffff >> (8 * lb));
      for (i = 0; i < 32; i = i + 1)
        expw[i] = pkt[i];
      iv = {tm[31:22], pkt[3][21:0], pkt[5][15:0], pkt[7][15:0], pkt[8]};
      if (sgn) begin
        expw[7][28] = 1'b1;
        expw[10] = {13'h1fff, key, 16'h0004};
        h = enc(key, 128'h0);
        y = 128'h0;
        for (i = 0; i < n; i = i + 4)
          y = gmul(y ^ {expw[i], expw[i+1], expw[i+2], expw[i+3]}, h);
        i = 32 * (n - 1) + 8 * ((lb == 2'h0) ? 4 : lb);
        y = gmul(y ^ {64'(i), 64'h0}, h);
        {expw[11], expw[12], expw[13], expw[14]} = y ^ enc(key, {iv, 32'h1});
      end
    end
  endtask
  task run_pkt(input integer n, input [1:0] lb, input [2:0] key, input sec,
               input sgn, input integer stall);
    integer i, k, w;
    reg [31:0] tm;
    begin
      tm = 32'h5a400000 + {key, 22'h0} + n;
      build(n, lb, key, sgn, tm);
      nb = 0;
      i = 0;
      k = 0;
      w = 0;
      in_key_idx_i <= key;
      in_security_stream_i <= sec;
      in_emission_time_i <= tm;
      fork
        begin
          while (i < n) begin
            in_valid_i <= 1'b1;
            in_data_i <= pkt[i];
            in_last_i <= (i == n - 1);
            in_last_bytes_i <= (i == n - 1) ? lb : 2'h0;
            @(posedge clk_sys_i);
            if (in_ready_o)
              i = i + 1;
          end
          in_valid_i <= 1'b0;
        end
        while (k < n && w < 3000) begin
          out_ready_i <= (stall == 0) || (w % stall != 0);
          @(posedge clk_sys_i);
          w = w + 1;
          if (out_valid_o && out_ready_i) begin
            check("out word", out_data_o, expw[k]);
            check("out flags", {out_last_o, out_signed_o, out_last_bytes_o},
                  {k == n - 1, sgn, (k == n - 1) ? lb : 2'h0});
            k = k + 1;
          end
        end
      join
      out_ready_i <= 1'b1;
      check("words out", k, n);
      check("cipher calls", nb, sgn ? 2 : 0);
      if (sgn) begin
        check("hash key block", blks[0], 128'h0);
        check("counter block", blks[1], {iv, 32'h1});
        check("key used", {kseen[0], kseen[1]}, {key, key});
      end
      w = 0;
      while (!in_ready_o && w < 100) begin
        @(posedge clk_sys_i);
        w = w + 1;
      end
      @(posedge clk_sys_i);
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_keys;
    integer key;
    begin
      for (key = 1; key <= 4; key = key + 1) begin
        delay <= (key % 2) ? 8'h00 : 8'h09;
        run_pkt(17, 2'(key), 3'(key), 1'b0, 1'b1, (key == 1) ? 0 : key + 1);
      end
    end
  endtask
  task t_unsigned;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        run_pkt(17, 2'h3, (i == 0) ? 3'h0 : 3'(i + 4), 1'b0, 1'b0, 2);
    end
  endtask
  task t_security;
    run_pkt(17, 2'h0, 3'h2, 1'b1, 1'b0, 0);
  endtask
  task t_bounds;
    begin
      run_pkt(14, 2'h1, 3'h1, 1'b0, 1'b0, 0);
      run_pkt(15, 2'h0, 3'h3, 1'b0, 1'b1, 3);
      run_pkt(1, 2'h2, 3'h1, 1'b0, 1'b0, 0);
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_keys;
    t_unsigned;
    t_security;
    t_bounds;
    finish_test;
  end
  // about four times the expected run of some 5000 cycles
  initial begin
    #1000000;
    err_total = err_total + 1;
    finish_test;
  end
endmodule
`default_nettype wire
